//--- core/tvas_defs.svh
// Register map, field positions, reset values and timing counts.
`ifndef TVAS_DEFS_SVH
`define TVAS_DEFS_SVH
// Register addresses (byte-wide registers, 4-bit address).
`define TVAS_A_NDIV_HI 4'h1
`define TVAS_A_NDIV_LO 4'h2
`define TVAS_A_RDIV 4'h3
`define TVAS_A_OSC 4'h4
`define TVAS_A_FILTER 4'h5
`define TVAS_A_CONTROL 4'h6
`define TVAS_A_STATUS1 4'h7
`define TVAS_A_STATUS2 4'h8
// Oscillator register fields.
`define TVAS_OSC_BAND_LSB 3
`define TVAS_OSC_AUTO_BIT 2
`define TVAS_OSC_SMP_EN_BIT 1
`define TVAS_OSC_LATCH_BIT 0
// Control register fields.
`define TVAS_CTL_STBY_BIT 7
`define TVAS_CTL_GAIN_LSB 0
// Status byte 1 fields.
`define TVAS_ST1_DONE_BIT 7
`define TVAS_ST1_OK_BIT 6
// Reset values.
`define TVAS_RST_BYTE 8'h00
`define TVAS_RST_BAND 5'h00
`define TVAS_RST_GAIN 4'h0
// Band limits and settling time per band step.
`define TVAS_BAND_MAX 5'h17
`define TVAS_SETTLE_NS 1000
`define TVAS_CLK_NS 10
`define TVAS_SETTLE_CYC ((`TVAS_SETTLE_NS + `TVAS_CLK_NS - 1) / `TVAS_CLK_NS)
`endif

//--- core/tvas_pkg.sv
// Types shared by the oscillator band control logic.
package tvas_pkg;
    typedef enum logic [1:0] {
        TVAS_IDLE = 2'b00,
        TVAS_SETTLE = 2'b01,
        TVAS_CHECK = 2'b10
    } tvas_state_e;
    typedef struct packed {
        logic done;
        logic success;
        logic [4:0] band;
    } tvas_search_s;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tvas_bus_s;
endpackage : tvas_pkg

//--- core/tvas_sync.sv
// Two-flip-flop synchroniser for the tuning-voltage code.
module tvas_sync
    import tvas_pkg::*;
#(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Data
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : tvas_sync

//--- core/tvas_top.sv
// Oscillator band selection, tuning-voltage sampler, gain and standby.
//
// Local design decisions: the address map and the plain strobed port.
`include "tvas_defs.svh"
module tvas_top
    import tvas_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Tuning-voltage comparator code from the analog side
    input wire logic [2:0] tune_voltage_node_i,
    // Analog controls
    output logic [4:0] osc_band_o,
    output logic [3:0] baseband_gain_code_o,
    output logic [7:0] filter_corner_code_o,
    output logic tune_sampler_enable_o,
    output logic active_o,
    output logic search_busy_o
);
    // ==========================================================
    // State
    typedef struct packed {
        tvas_state_e state;
        logic [7:0] ndiv_hi;
        logic [7:0] ndiv_lo;
        logic [7:0] rdiv;
        logic [4:0] osc_band_select;
        logic auto_band_enable;
        logic tune_sampler_enable;
        logic [7:0] filter_corner_code;
        logic [3:0] baseband_gain_code;
        logic standby_request;
        tvas_search_s search;
        logic [4:0] try_band;
        logic [4:0] tries;
        logic [7:0] settle;
        logic [2:0] latched_code;
        logic [7:0] rdata;
    } tvas_regs_s;

    tvas_regs_s st_q;
    tvas_regs_s st_d;
    tvas_bus_s bus;
    logic [2:0] code_sync;
    logic [7:0] status1;
    logic [7:0] status2;
    logic [4:0] cur_band;
    logic code_selectable;

    assign bus = '{addr: reg_addr_i, wdata: reg_wdata_i,
                   wr: reg_wr_i, rd: reg_rd_i};

    tvas_sync #(.WIDTH(3)) u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .async_i(tune_voltage_node_i),
        .sync_o(code_sync)
    );

    // ==========================================================
    // Status and decoding
    // Only the two inner codes leave drift margin for a search pick.
    assign code_selectable = (code_sync == 3'h2) || (code_sync == 3'h5);
    assign cur_band = st_q.auto_band_enable ? st_q.search.band
                                            : st_q.osc_band_select;
    assign status1 = {st_q.search.done, st_q.search.success, 6'h00};
    assign status2 = {cur_band, st_q.latched_code};

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        if (bus.wr) begin
            // Writes are accepted in standby too; nothing is reset by it.
            unique case (bus.addr)
                `TVAS_A_NDIV_HI: st_d.ndiv_hi = bus.wdata;
                `TVAS_A_NDIV_LO: st_d.ndiv_lo = bus.wdata;
                `TVAS_A_RDIV: st_d.rdiv = bus.wdata;
                `TVAS_A_OSC: begin
                    st_d.osc_band_select =
                        bus.wdata[`TVAS_OSC_BAND_LSB +: 5];
                    st_d.auto_band_enable = bus.wdata[`TVAS_OSC_AUTO_BIT];
                    st_d.tune_sampler_enable =
                        bus.wdata[`TVAS_OSC_SMP_EN_BIT];
                    if (bus.wdata[`TVAS_OSC_LATCH_BIT]) begin
                        st_d.latched_code = code_sync;
                    end
                end
                `TVAS_A_FILTER: st_d.filter_corner_code = bus.wdata;
                `TVAS_A_CONTROL: begin
                    st_d.standby_request = bus.wdata[`TVAS_CTL_STBY_BIT];
                    st_d.baseband_gain_code =
                        bus.wdata[`TVAS_CTL_GAIN_LSB +: 4];
                end
                default: begin
                end
            endcase
        end
        // Search sequencer, halted while in standby.
        if (!st_q.standby_request) begin
            unique case (st_q.state)
                TVAS_IDLE: begin
                end
                TVAS_SETTLE: begin
                    if (st_q.settle == 8'h00) begin
                        st_d.state = TVAS_CHECK;
                    end else begin
                        st_d.settle = st_q.settle - 8'h01;
                    end
                end
                TVAS_CHECK: begin
                    if (code_selectable) begin
                        st_d.search.done = 1'b1;
                        st_d.search.success = 1'b1;
                        st_d.search.band = st_q.try_band;
                        st_d.state = TVAS_IDLE;
                    end else if (st_q.tries == `TVAS_BAND_MAX) begin
                        st_d.search.done = 1'b1;
                        st_d.search.success = 1'b0;
                        st_d.state = TVAS_IDLE;
                    end else begin
                        st_d.tries = st_q.tries + 5'h01;
                        st_d.try_band = (st_q.try_band == `TVAS_BAND_MAX)
                                        ? 5'h00 : st_q.try_band + 5'h01;
                        st_d.search.band = st_d.try_band;
                        st_d.settle = 8'(`TVAS_SETTLE_CYC - 1);
                        st_d.state = TVAS_SETTLE;
                    end
                end
                default: st_d.state = TVAS_IDLE;
            endcase
        end
        // A low N byte write starts or restarts the search when auto band is enabled.
        if (bus.wr && bus.addr == `TVAS_A_NDIV_LO &&
            st_d.auto_band_enable) begin
            st_d.state = TVAS_SETTLE;
            st_d.search.done = 1'b0;
            st_d.search.success = 1'b0;
            st_d.try_band = st_d.osc_band_select;
            st_d.search.band = st_d.osc_band_select;
            st_d.tries = 5'h00;
            st_d.settle = 8'(`TVAS_SETTLE_CYC - 1);
        end
        st_d.rdata = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                `TVAS_A_NDIV_HI: st_d.rdata = st_q.ndiv_hi;
                `TVAS_A_NDIV_LO: st_d.rdata = st_q.ndiv_lo;
                `TVAS_A_RDIV: st_d.rdata = st_q.rdiv;
                `TVAS_A_OSC: st_d.rdata = {st_q.osc_band_select,
                    st_q.auto_band_enable, st_q.tune_sampler_enable, 1'b0};
                `TVAS_A_FILTER: st_d.rdata = st_q.filter_corner_code;
                `TVAS_A_CONTROL: st_d.rdata = {st_q.standby_request,
                    3'h0, st_q.baseband_gain_code};
                `TVAS_A_STATUS1: st_d.rdata = status1;
                `TVAS_A_STATUS2: st_d.rdata = status2;
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= '{state: TVAS_IDLE, ndiv_hi: `TVAS_RST_BYTE,
                ndiv_lo: `TVAS_RST_BYTE, rdiv: `TVAS_RST_BYTE,
                osc_band_select: `TVAS_RST_BAND, auto_band_enable: 1'b0,
                tune_sampler_enable: 1'b0,
                filter_corner_code: `TVAS_RST_BYTE,
                baseband_gain_code: `TVAS_RST_GAIN, standby_request: 1'b0,
                search: '{done: 1'b1, success: 1'b0, band: `TVAS_RST_BAND},
                try_band: `TVAS_RST_BAND, tries: 5'h00, settle: 8'h00,
                latched_code: 3'h0, rdata: 8'h00};
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Outputs; sampler enable and active forced low in standby while contents are kept.
    logic [4:0] band_q;
    logic [3:0] gain_q;
    logic [7:0] filt_q;
    logic smp_q;
    logic act_q;
    logic busy_q;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            band_q <= 5'h00;
            gain_q <= 4'h0;
            filt_q <= 8'h00;
            smp_q <= 1'b0;
            act_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            band_q <= st_d.auto_band_enable ? st_d.search.band
                                            : st_d.osc_band_select;
            gain_q <= st_d.baseband_gain_code;
            filt_q <= st_d.filter_corner_code;
            smp_q <= st_d.tune_sampler_enable && !st_d.standby_request;
            act_q <= !st_d.standby_request;
            busy_q <= (st_d.state != TVAS_IDLE);
        end
    end
    assign reg_rdata_o = st_q.rdata;
    assign osc_band_o = band_q;
    assign baseband_gain_code_o = gain_q;
    assign filter_corner_code_o = filt_q;
    assign tune_sampler_enable_o = smp_q;
    assign active_o = act_q;
    assign search_busy_o = busy_q;
endmodule : tvas_top

//--- verif/tvas_top_checker.sv
// Port assertions for the band control block.
`include "tvas_defs.svh"
module tvas_top_checker
    import tvas_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // Register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // Analog side
    input wire logic [2:0] tune_voltage_node_i,
    input wire logic [4:0] osc_band_o,
    input wire logic [3:0] baseband_gain_code_o,
    input wire logic [7:0] filter_corner_code_o,
    input wire logic tune_sampler_enable_o,
    input wire logic active_o,
    input wire logic search_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Search length
    logic [11:0] busy_cnt_q;
    logic wr_lo;
    assign wr_lo = reg_wr_i && reg_addr_i == `TVAS_A_NDIV_LO;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_cnt_q <= 12'h000;
        end else if (!search_busy_o || wr_lo) begin
            busy_cnt_q <= 12'h000;
        end else if (active_o) begin
            busy_cnt_q <= busy_cnt_q + 12'h001;
        end
    end
    // ==========
    // Assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    a_read_quiet: assert property (reg_rdata_o != 8'h00 |-> $past(reg_rd_i))
        else $error("read data outside read cycle");
    a_gain_apply: assert property (
        reg_wr_i && reg_addr_i == `TVAS_A_CONTROL
        |=> baseband_gain_code_o == $past(reg_wdata_i[3:0]))
        else $error("gain code not applied");
    a_standby_enter: assert property (
        reg_wr_i && reg_addr_i == `TVAS_A_CONTROL
        |=> active_o == !$past(reg_wdata_i[7]))
        else $error("standby state wrong");
    a_standby_gates: assert property (
        tune_sampler_enable_o |-> active_o)
        else $error("sampler on in standby");
    a_manual_band: assert property (
        reg_wr_i && reg_addr_i == `TVAS_A_OSC && !reg_wdata_i[2]
        |=> osc_band_o == $past(reg_wdata_i[7:3]))
        else $error("manual band not applied");
    a_search_cause: assert property (
        $rose(search_busy_o) |-> $past(wr_lo))
        else $error("search started without trigger");
    a_done_low: assert property (
        reg_rd_i && reg_addr_i == `TVAS_A_STATUS1 && search_busy_o
        |=> !reg_rdata_o[7])
        else $error("done flag set while searching");
    a_status_band: assert property (
        reg_rd_i && reg_addr_i == `TVAS_A_STATUS2
        |=> reg_rdata_o[7:3] == $past(osc_band_o))
        else $error("band readback wrong");
    a_search_bound: assert property (busy_cnt_q <= 12'd2440)
        else $error("search ran too long");
endmodule : tvas_top_checker
bind tvas_top tvas_top_checker u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .tune_voltage_node_i(tune_voltage_node_i), .osc_band_o(osc_band_o),
    .baseband_gain_code_o(baseband_gain_code_o),
    .filter_corner_code_o(filter_corner_code_o),
    .tune_sampler_enable_o(tune_sampler_enable_o), .active_o(active_o),
    .search_busy_o(search_busy_o));

//--- verif/tvas_vco_model.sv
// Behavioural tune-voltage model of the oscillator bank.
module tvas_vco_model
    import tvas_pkg::*;
(
    // Band and scenario controls
    input wire logic [4:0] band_i,
    input wire logic active_i,
    input wire logic [4:0] tgt_i,
    input wire logic [4:0] alt_i,
    input wire logic ovr_en_i,
    input wire logic [2:0] ovr_code_i,
    // Comparator code
    output logic [2:0] code_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A stopped signal path leaves the tune node at the rail.
    assign code_o = ovr_en_i ? ovr_code_i : !active_i ? 3'b000 :
        band_i == tgt_i ? 3'b010 : band_i == alt_i ? 3'b101 : 3'b001;
endmodule : tvas_vco_model

//--- verif/tvas_top_tb.sv
// Self-checking testbench for the band control block.
`include "tvas_defs.svh"
module tvas_top_tb;
    import tvas_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset_n, wr_s, rd_s, ovr_en, smp, act, busy;
    logic [3:0] addr, gain;
    logic [7:0] wdata, rdata, filt, v;
    logic [4:0] band, tgt, alt, b;
    logic [2:0] code, ovr_code;
    logic [31:0] seed;
    int fail_count, samples_checked, cyc;
    // ==========
    // Design and oscillator model
    tvas_top uut (.mclk_i(mclk), .reset_n_i(reset_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .tune_voltage_node_i(code), .osc_band_o(band),
        .baseband_gain_code_o(gain), .filter_corner_code_o(filt),
        .tune_sampler_enable_o(smp), .active_o(act), .search_busy_o(busy));
    tvas_vco_model u_vco (.band_i(band), .active_i(act), .tgt_i(tgt),
        .alt_i(alt), .ovr_en_i(ovr_en), .ovr_code_i(ovr_code), .code_o(code));
    // ==========
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic wait_idle();
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
        end
        chk({7'h00, busy}, 8'h00);
    endtask : wait_idle
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    // ==========
    // Clock and timeout
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    // ==========
    // Scenarios
    initial begin
        {reset_n, wr_s, rd_s, ovr_en, addr, wdata, ovr_code} = '0;
        tgt = 5'h1F;
        alt = 5'h1F;
        seed = 32'hA3F9;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`TVAS_A_STATUS1, v);
        chk(v & 8'hC0, 8'h80);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            wr(`TVAS_A_CONTROL, {4'h0, seed[3:0]});
            wr(`TVAS_A_FILTER, seed[15:8]);
            chk({4'h0, gain}, {4'h0, seed[3:0]});
            chk(filt, seed[15:8]);
            b = 5'(seed[23:16] % 24);
            wr(`TVAS_A_OSC, {b, 3'b000});
            chk({3'h0, band}, {3'h0, b});
            rd(`TVAS_A_STATUS2, v);
            chk({3'h0, v[7:3]}, {3'h0, b});
        end
        $display("test registers done");
        ovr_en = 1'b1;
        for (int c = 0; c < 8; c++) begin
            ovr_code = 3'(c);
            wr(`TVAS_A_OSC, 8'h02);
            repeat (3) @(posedge mclk);
            wr(`TVAS_A_OSC, 8'h03);
            ovr_code = ~3'(c);
            repeat (3) @(posedge mclk);
            rd(`TVAS_A_STATUS2, v);
            chk({5'h00, v[2:0]}, {5'h00, 3'(c)});
        end
        $display("test sampler done");
        ovr_en = 1'b0;
        tgt = 5'd7;
        alt = 5'd3;
        wr(`TVAS_A_OSC, {5'd6, 3'b110});
        wr(`TVAS_A_NDIV_HI, seed[7:0]);
        wr(`TVAS_A_NDIV_LO, seed[15:8]);
        rd(`TVAS_A_STATUS1, v);
        chk(v & 8'h80, 8'h00);
        wait_idle();
        rd(`TVAS_A_STATUS1, v);
        chk(v & 8'hC0, 8'hC0);
        rd(`TVAS_A_STATUS2, v);
        chk({3'h0, v[7:3]}, 8'h07);
        tgt = 5'h1F;
        alt = 5'd9;
        wr(`TVAS_A_NDIV_LO, 8'h10);
        wait_idle();
        rd(`TVAS_A_STATUS2, v);
        chk({3'h0, v[7:3]}, 8'h09);
        $display("test search done");
        alt = 5'h1F;
        wr(`TVAS_A_NDIV_LO, 8'h11);
        repeat (150) @(posedge mclk);
        wr(`TVAS_A_NDIV_LO, 8'h11);
        chk({3'h0, band}, 8'h06);
        rd(`TVAS_A_STATUS1, v);
        chk(v & 8'h80, 8'h00);
        wait_idle();
        rd(`TVAS_A_STATUS1, v);
        chk(v & 8'hC0, 8'h80);
        $display("test failed search done");
        wr(`TVAS_A_CONTROL, 8'h85);
        chk({6'h00, act, smp}, 8'h00);
        wr(`TVAS_A_FILTER, 8'h5A);
        wr(`TVAS_A_CONTROL, 8'h05);
        chk({act, smp, 2'b00, gain}, 8'hC5);
        chk(filt, 8'h5A);
        wr(`TVAS_A_STATUS1, 8'h00);
        rd(`TVAS_A_STATUS1, v);
        chk(v & 8'hC0, 8'h80);
        rd(4'hF, v);
        chk(v, 8'h00);
        $display("test standby done");
        test_done();
    end
endmodule : tvas_top_tb
